// File: hw/timer_io_pkg.sv
// Purpose: shared constants for the timer pin I/O control decode block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: register offsets are byte addresses
package timer_io_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CH5_IO = 8'h00;
   localparam logic [7:0] OFS_CH0_IO_HIGH = 8'h04;
   localparam logic [7:0] OFS_CH0_IO_LOW = 8'h08;
   localparam logic [7:0] OFS_CH0_MODE = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_PIN_STATE = 8'h18;
   localparam logic [7:0] OFS_GEN_REG0 = 8'h1c;
   localparam logic [7:0] OFS_GEN_REG1 = 8'h20;
   localparam logic [7:0] OFS_GEN_REG2 = 8'h24;
   // field positions
   localparam int FIELD_B_LSB = 4;
   localparam int FIELD_AC_LSB = 0;
   localparam int BUF_A_BIT = 0;
   localparam int IRQ_CAP_LSB = 0;
   localparam int IRQ_CMP_LSB = 3;
   localparam int PIN_OE_LSB = 3;
   // reset values
   localparam logic [7:0] IO_CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [5:0] IRQ_RESET = 6'h00;
   // field indices
   localparam int NUM_FIELDS = 3;
   localparam int IDX_CH5_B = 0;
   localparam int IDX_CH0_A = 1;
   localparam int IDX_CH0_C = 2;
   // action taken on a compare match, from the two low code bits
   typedef enum logic [1:0] {
      ACT_NONE = 2'b00,
      ACT_LOW = 2'b01,
      ACT_HIGH = 2'b10,
      ACT_TOGGLE = 2'b11
   } match_action_t;

   // a code with bit 3 set makes the general register a capture register
   function automatic logic is_capture(input logic [3:0] code);
      return code[3];
   endfunction
endpackage

// File: hw/timer_io_field.sv
// Purpose: one pin I/O control field: pin level, oe and capture trigger
// Assumes: pin input and trigger inputs are synchronous to ref_clk
// Notes: code_load pulses in the first cycle the new code is visible
`timescale 1ns/100ps
`default_nettype none
module timer_io_field
   import timer_io_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter bit INTERNAL_SRC = 1'b0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // control
   input wire logic [3:0] code,
   input wire logic code_load,
   input wire logic blocked,
   // timer events
   input wire logic compare_match,
   input wire logic internal_trig,
   input wire logic [CNT_W-1:0] counter,
   // software access to the general register
   input wire logic gr_wr,
   input wire logic [CNT_W-1:0] gr_wdata,
   // pin and results
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic capture_pulse,
   output logic compare_pulse,
   output logic [CNT_W-1:0] general_reg
);
   logic pin_reg, pin_next, oe_reg, oe_next, prev_reg, prev_next;
   logic cap_reg, cap_next, cmp_reg, cmp_next;
   logic [CNT_W-1:0] gr_reg, gr_next;
   logic out_mode, edge_hit;
   match_action_t act;

   // next pin level, enable and capture decision
   always_comb begin
      out_mode = !is_capture(code);
      act = match_action_t'(code[1:0]);
      pin_next = pin_reg;
      oe_next = out_mode && (act != ACT_NONE);
      prev_next = pin_in;
      // buffer use of the register suppresses both functions
      cmp_next = out_mode && compare_match && !blocked && (act != ACT_NONE);
      if (code_load && out_mode) begin
         pin_next = code[2];
      end else if (cmp_next) begin
         case (act)
            ACT_LOW: pin_next = 1'b0;
            ACT_HIGH: pin_next = 1'b1;
            ACT_TOGGLE: pin_next = !pin_reg;
            default: pin_next = pin_reg;
         endcase
      end
      if (code[2]) begin
         // internal source only where the field offers one
         edge_hit = INTERNAL_SRC && internal_trig;
      end else if (code[1]) begin
         edge_hit = pin_in != prev_reg;
      end else if (code[0]) begin
         edge_hit = prev_reg && !pin_in;
      end else begin
         edge_hit = !prev_reg && pin_in;
      end
      cap_next = is_capture(code) && !blocked && edge_hit;
      // a capture wins over a software write in the same cycle
      if (cap_next) begin
         gr_next = counter;
      end else if (gr_wr) begin
         gr_next = gr_wdata;
      end else begin
         gr_next = gr_reg;
      end
   end

   // registers only
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pin_reg <= 1'b0;
         oe_reg <= 1'b0;
         prev_reg <= 1'b0;
         cap_reg <= 1'b0;
         cmp_reg <= 1'b0;
         gr_reg <= '0;
      end else begin
         pin_reg <= pin_next;
         oe_reg <= oe_next;
         prev_reg <= prev_next;
         cap_reg <= cap_next;
         cmp_reg <= cmp_next;
         gr_reg <= gr_next;
      end
   end

   assign pin_out = pin_reg;
   assign pin_oe = oe_reg;
   assign capture_pulse = cap_reg;
   assign compare_pulse = cmp_reg;
   assign general_reg = gr_reg;
endmodule
`default_nettype wire

// File: hw/timer_io_control_decode.sv
// Purpose: timer pin I/O control decode for three general registers
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: field 0 is channel 5 B, 1 is channel 0 A, 2 is channel 0 C
// Function
// - codes 0000/0100 disable; 0001-0011 start low
// - codes 0101-0111 compare, pin starts high
// - low bits 01: pin low on match
// - low bits 10: pin high on match
// - low bits 11: pin toggles on match
// - code 1000 captures on rising pin edge
// - code 1001 captures on falling pin edge
// - code 101x captures on both edges
// - field A 11xx captures on channel 1 count
// - buffer mode blocks field C functions
`timescale 1ns/100ps
`default_nettype none
module timer_io_control_decode
   import timer_io_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // timer events and counters; compare match one bit per field, one shared channel 1 count
   input wire logic [NUM_FIELDS-1:0] compare_match,
   input wire logic ch1_count_event,
   input wire logic [CNT_W-1:0] ch5_counter,
   input wire logic [CNT_W-1:0] ch0_counter,
   // pins, one bit per field
   input wire logic [NUM_FIELDS-1:0] pin_in,
   output logic [NUM_FIELDS-1:0] pin_out,
   output logic [NUM_FIELDS-1:0] pin_oe,
   // capture strobes and interrupt
   output logic [NUM_FIELDS-1:0] capture_pulse,
   output logic irq
);
   logic [7:0] io5_reg, io5_next, ioh_reg, ioh_next, iol_reg, iol_next;
   logic [7:0] mode_reg, mode_next;
   logic [5:0] status_reg, status_next, mask_reg, mask_next;
   logic [7:0] addr_reg, addr_next;
   logic wr_pend_reg, wr_pend_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [NUM_FIELDS-1:0] load_reg, load_next, gr_wr, cmp_pulse, blocked;
   logic [3:0] codes [NUM_FIELDS];
   logic [CNT_W-1:0] gen_regs [NUM_FIELDS];
   logic [CNT_W-1:0] counters [NUM_FIELDS];
   logic [CNT_W-1:0] gr_wdata;
   logic wr_now, rd_take;

   // each code sits in its own nibble of its control register
   assign codes[IDX_CH5_B] = io5_reg[FIELD_B_LSB+3:FIELD_B_LSB];
   assign codes[IDX_CH0_A] = ioh_reg[FIELD_AC_LSB+3:FIELD_AC_LSB];
   assign codes[IDX_CH0_C] = iol_reg[FIELD_AC_LSB+3:FIELD_AC_LSB];
   assign counters[IDX_CH5_B] = ch5_counter;
   assign counters[IDX_CH0_A] = ch0_counter;
   assign counters[IDX_CH0_C] = ch0_counter;
   // only the C register can serve as buffer of A
   assign blocked[IDX_CH5_B] = 1'b0;
   assign blocked[IDX_CH0_A] = 1'b0;
   assign blocked[IDX_CH0_C] = mode_reg[BUF_A_BIT];
   assign gr_wdata = hwdata[CNT_W-1:0];
   assign wr_now = wr_pend_reg;

   // data-phase write strobes for the general registers
   always_comb begin
      gr_wr = '0;
      if (wr_now) begin
         if (addr_reg == OFS_GEN_REG0) begin
            gr_wr[0] = 1'b1;
         end else if (addr_reg == OFS_GEN_REG1) begin
            gr_wr[1] = 1'b1;
         end else if (addr_reg == OFS_GEN_REG2) begin
            gr_wr[2] = 1'b1;
         end
      end
   end

   // one decoder per field; the A and C fields of channel 0 may capture
   // on channel 1 counting, the channel 5 field has no such source
   genvar gi;
   generate
      for (gi = 0; gi < NUM_FIELDS; gi++) begin : g_field
         timer_io_field #(
            .CNT_W(CNT_W),
            .INTERNAL_SRC(gi != IDX_CH5_B)
         ) u_field (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .code(codes[gi]),
            .code_load(load_reg[gi]),
            .blocked(blocked[gi]),
            .compare_match(compare_match[gi]),
            .internal_trig(ch1_count_event),
            .counter(counters[gi]),
            .gr_wr(gr_wr[gi]),
            .gr_wdata(gr_wdata),
            .pin_in(pin_in[gi]),
            .pin_out(pin_out[gi]),
            .pin_oe(pin_oe[gi]),
            .capture_pulse(capture_pulse[gi]),
            .compare_pulse(cmp_pulse[gi]),
            .general_reg(gen_regs[gi])
         );
      end
   endgenerate

   // bus address phase, register writes and read data
   always_comb begin
      rd_take = hsel && hready && htrans[1];
      addr_next = rd_take ? haddr : addr_reg;
      wr_pend_next = rd_take && hwrite;
      io5_next = io5_reg;
      ioh_next = ioh_reg;
      iol_next = iol_reg;
      mode_next = mode_reg;
      mask_next = mask_reg;
      load_next = '0;
      // events always land, even on the cycle software clears them
      status_next = status_reg;
      if (wr_now) begin
         if (addr_reg == OFS_CH5_IO) begin
            io5_next = hwdata[7:0];
            load_next[IDX_CH5_B] = 1'b1;
         end else if (addr_reg == OFS_CH0_IO_HIGH) begin
            ioh_next = hwdata[7:0];
            load_next[IDX_CH0_A] = 1'b1;
         end else if (addr_reg == OFS_CH0_IO_LOW) begin
            iol_next = hwdata[7:0];
            load_next[IDX_CH0_C] = 1'b1;
         end else if (addr_reg == OFS_CH0_MODE) begin
            mode_next = hwdata[7:0];
         end else if (addr_reg == OFS_IRQ_STATUS) begin
            status_next = status_reg & ~hwdata[5:0];
         end else if (addr_reg == OFS_IRQ_MASK) begin
            mask_next = hwdata[5:0];
         end
      end
      status_next[IRQ_CAP_LSB +: NUM_FIELDS] =
         status_next[IRQ_CAP_LSB +: NUM_FIELDS] | capture_pulse;
      status_next[IRQ_CMP_LSB +: NUM_FIELDS] =
         status_next[IRQ_CMP_LSB +: NUM_FIELDS] | cmp_pulse;
      // read data is fetched in the address phase so no wait is needed
      rdata_next = 32'h0000_0000;
      if (rd_take && !hwrite) begin
         if (haddr == OFS_CH5_IO) begin
            rdata_next[7:0] = io5_reg;
         end else if (haddr == OFS_CH0_IO_HIGH) begin
            rdata_next[7:0] = ioh_reg;
         end else if (haddr == OFS_CH0_IO_LOW) begin
            rdata_next[7:0] = iol_reg;
         end else if (haddr == OFS_CH0_MODE) begin
            rdata_next[7:0] = mode_reg;
         end else if (haddr == OFS_IRQ_STATUS) begin
            rdata_next[5:0] = status_reg;
         end else if (haddr == OFS_IRQ_MASK) begin
            rdata_next[5:0] = mask_reg;
         end else if (haddr == OFS_PIN_STATE) begin
            rdata_next[PIN_OE_LSB +: NUM_FIELDS] = pin_oe;
            rdata_next[NUM_FIELDS-1:0] = pin_out;
         end else if (haddr == OFS_GEN_REG0) begin
            rdata_next[CNT_W-1:0] = gen_regs[0];
         end else if (haddr == OFS_GEN_REG1) begin
            rdata_next[CNT_W-1:0] = gen_regs[1];
         end else if (haddr == OFS_GEN_REG2) begin
            rdata_next[CNT_W-1:0] = gen_regs[2];
         end
      end
   end

   // registers only
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         io5_reg <= IO_CTRL_RESET;
         ioh_reg <= IO_CTRL_RESET;
         iol_reg <= IO_CTRL_RESET;
         mode_reg <= MODE_RESET;
         status_reg <= IRQ_RESET;
         mask_reg <= IRQ_RESET;
         addr_reg <= 8'h00;
         wr_pend_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         load_reg <= '0;
      end else begin
         io5_reg <= io5_next;
         ioh_reg <= ioh_next;
         iol_reg <= iol_next;
         mode_reg <= mode_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         addr_reg <= addr_next;
         wr_pend_reg <= wr_pend_next;
         rdata_reg <= rdata_next;
         load_reg <= load_next;
      end
   end

   // never stalls and never errors; unmapped reads give zero
   assign hrdata = rdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = |(status_reg & mask_reg);
endmodule
`default_nettype wire

// File: bench/timer_io_control_decode_checker.sv
// Purpose: port assertions for the timer pin decode block
// Assumes: zero wait states, codes shadowed from bus writes
// Notes: a write in flight masks the match checks, as it reloads pins
`timescale 1ns/100ps
`default_nettype none
module timer_io_control_decode_checker
   import timer_io_pkg::*;
(
   // clock, reset and bus
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // timer side
   input wire logic [NUM_FIELDS-1:0] compare_match,
   input wire logic ch1_count_event,
   input wire logic [NUM_FIELDS-1:0] pin_in,
   input wire logic [NUM_FIELDS-1:0] pin_out,
   input wire logic [NUM_FIELDS-1:0] pin_oe,
   input wire logic [NUM_FIELDS-1:0] capture_pulse
);
   logic ap_wr, wr_d, buf_r;
   logic [7:0] ap_addr;
   logic [3:0] code_b, code_a, code_c;
   wire quiet = !ap_wr && !wr_d;
   wire wr_b = ap_wr && ap_addr == OFS_CH5_IO;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // shadow codes land at the data phase edge, as the registers do
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ap_wr <= 1'b0;
         wr_d <= 1'b0;
         buf_r <= 1'b0;
         code_b <= 4'h0;
         code_a <= 4'h0;
         code_c <= 4'h0;
      end else begin
         ap_wr <= hsel && hready && htrans[1] && hwrite;
         ap_addr <= haddr;
         wr_d <= ap_wr;
         if (wr_b) code_b <= hwdata[7:4];
         if (ap_wr && ap_addr == OFS_CH0_IO_HIGH) code_a <= hwdata[3:0];
         if (ap_wr && ap_addr == OFS_CH0_IO_LOW) code_c <= hwdata[3:0];
         if (ap_wr && ap_addr == OFS_CH0_MODE) buf_r <= hwdata[0];
      end
   end
   dis_b_a: assert property (
      (($past(code_b) & 4'hb) == 4'h0) |-> !pin_oe[0])
      else $error("field b drives with a disable code");
   init_b_a: assert property (
      wr_b && !hwdata[7] && hwdata[5:4] != 2'b00 ##1 !compare_match[0] &&
      !wr_b |=> pin_oe[0] && pin_out[0] == code_b[2])
      else $error("field b initial level wrong");
   match_low_a: assert property (
      !code_a[3] && code_a[1:0] == 2'b01 && compare_match[1] && quiet
      |=> !pin_out[1]) else $error("match did not drive low");
   match_high_a: assert property (
      !code_a[3] && code_a[1:0] == 2'b10 && compare_match[1] && quiet
      |=> pin_out[1]) else $error("match did not drive high");
   match_tog_a: assert property (
      !code_a[3] && code_a[1:0] == 2'b11 && compare_match[1] && quiet
      |=> pin_out[1] != $past(pin_out[1])) else $error("no toggle");
   rise_cap_a: assert property (
      code_a == 4'h8 && pin_in[1] && !$past(pin_in[1]) |=> capture_pulse[1])
      else $error("no capture on rising edge");
   fall_cap_a: assert property (
      code_a == 4'h9 && !pin_in[1] && $past(pin_in[1]) |=> capture_pulse[1])
      else $error("no capture on falling edge");
   both_cap_a: assert property (
      code_a[3:1] == 3'b101 && $changed(pin_in[1]) |=> capture_pulse[1])
      else $error("no capture on pin change");
   ch1_cap_a: assert property (
      code_a[3:2] == 2'b11 && ch1_count_event |=> capture_pulse[1])
      else $error("no capture on channel 1 count");
   buf_cmp_a: assert property (
      buf_r && !code_c[3] && compare_match[2] && quiet |=> $stable(pin_out[2]))
      else $error("buffered field c acted on match");
endmodule
bind timer_io_control_decode timer_io_control_decode_checker checker_i (
   .ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .compare_match, .ch1_count_event, .pin_in, .pin_out, .pin_oe,
   .capture_pulse);
`default_nettype wire

// File: bench/timer_io_control_decode_tb.sv
// Purpose: self-checking bench for the timer pin decode block
// Assumes: zero wait state bus, one clock at 10 MHz
// Notes: rows drive field a; field b, c and reset follow by hand
`timescale 1ns/100ps
`default_nettype none
module timer_io_control_decode_tb
   import timer_io_pkg::*;
;
   logic ref_clk, resetn, hsel, hwrite, hreadyout, hresp, irq;
   logic ch1_count_event;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize, compare_match, pin_in, pin_out, pin_oe, capture_pulse;
   logic [31:0] hwdata, hrdata, q;
   logic [15:0] ch5_counter, ch0_counter;
   int errors, tests_run;
   // code; then oe, initial, after match or pin before, after, captured
   logic [6:0] rows [15] = '{7'h00, 7'h0c, 7'h15, 7'h1d, 7'h20, 7'h2e,
      7'h37, 7'h3e, 7'h43, 7'h44, 7'h4d, 7'h4a, 7'h53, 7'h5d, 7'h61};
   timer_io_control_decode timer_io_control_decode_i (
      .ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .compare_match,
      .ch1_count_event, .ch5_counter, .ch0_counter, .pin_in, .pin_out,
      .pin_oe, .capture_pulse, .irq);
   // 100 ns period
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // outputs are looked at mid-cycle, clear of edge updates
   task look;
      @(negedge ref_clk);
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one single word transfer; read data kept in q
   // it opens on a rising edge, so a caller left on a falling edge
   // cannot stretch the address phase over two edges
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      tick(1);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do look; while (hreadyout !== 1'b1);
      tick(1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do look; while (hreadyout !== 1'b1);
      q = hrdata;
      tick(1);
   endtask
   task match(input int f);
      compare_match[f] <= 1'b1;
      tick(1);
      compare_match[f] <= 1'b0;
      look;
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // the run needs about 250 cycles
   initial begin
      tick(5000);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test;
   end
   initial begin
      {resetn, hsel, hwrite, ch1_count_event} = 4'h0;
      {haddr, htrans, compare_match, pin_in} = 16'h0000;
      hsize = 3'b010;
      hwdata = 32'h0;
      {ch5_counter, ch0_counter} = 32'h0;
      tick(5);
      resetn <= 1'b1;
      tick(1);
      foreach (rows[i]) begin
         if (rows[i][6]) begin
            pin_in[1] <= rows[i][2];
            ch0_counter <= 16'h1000 + 16'(i);
            tick(2);
         end
         bus(1'b1, OFS_CH0_IO_HIGH, {28'h0, rows[i][6:3]});
         if (!rows[i][6]) begin
            tick(1);
            look;
            chk(pin_oe[1], rows[i][2]);
            if (rows[i][2]) chk(pin_out[1], rows[i][1]);
            tick(1);
            match(1);
            if (rows[i][2]) chk(pin_out[1], rows[i][0]);
            tick(1);
         end else begin
            bus(1'b1, OFS_IRQ_STATUS, 32'h3f);
            pin_in[1] <= rows[i][1];
            ch1_count_event <= rows[i][5];
            tick(1);
            ch1_count_event <= 1'b0;
            tick(2);
            bus(1'b0, OFS_IRQ_STATUS, 32'h0);
            chk(q[1], rows[i][0]);
            bus(1'b0, OFS_GEN_REG1, 32'h0);
            if (rows[i][0]) chk(q, 32'h1000 + 32'(i));
         end
         $display("row %0d done", i);
      end
      // last row left a capture pending: mask it in, then clear it
      look;
      chk(irq, 1'b0);
      bus(1'b1, OFS_IRQ_MASK, 32'h02);
      tick(2);
      look;
      chk(irq, 1'b1);
      bus(1'b1, OFS_IRQ_STATUS, 32'h02);
      tick(2);
      look;
      chk(irq, 1'b0);
      $display("interrupt test done");
      // field b sits in the upper nibble; upper bus bits read zero
      bus(1'b1, OFS_CH5_IO, 32'hffffff50);
      bus(1'b0, OFS_CH5_IO, 32'h0);
      chk(q, 32'h50);
      chk({pin_oe[0], pin_out[0]}, 2'b11);
      // pin state: field b drives high, fields a and c are released
      bus(1'b0, OFS_PIN_STATE, 32'h0);
      chk(q, 32'h0000_0009);
      // an output field never captures, so the software write stays
      bus(1'b1, OFS_GEN_REG0, 32'h1234_abcd);
      bus(1'b0, OFS_GEN_REG0, 32'h0);
      chk(q, 32'h0000_abcd);
      bus(1'b1, OFS_CH5_IO, 32'h05);
      tick(1);
      look;
      chk(pin_oe[0], 1'b0);
      $display("field b test done");
      // buffer mode: field c keeps its level and ignores pin edges
      bus(1'b1, OFS_CH0_MODE, 32'h01);
      bus(1'b1, OFS_CH0_IO_LOW, 32'h05);
      tick(2);
      match(2);
      chk({pin_oe[2], pin_out[2]}, 2'b11);
      tick(1);
      bus(1'b1, OFS_CH0_IO_LOW, 32'h08);
      bus(1'b1, OFS_IRQ_STATUS, 32'h3f);
      pin_in[2] <= 1'b1;
      tick(3);
      bus(1'b0, OFS_IRQ_STATUS, 32'h0);
      chk(q[2], 1'b0);
      $display("buffer test done");
      // reset while a pin drives, then an unmapped read
      bus(1'b1, OFS_CH0_IO_HIGH, 32'h05);
      tick(1);
      look;
      chk(pin_oe, 3'b010);
      tick(1);
      resetn <= 1'b0;
      tick(5);
      resetn <= 1'b1;
      look;
      chk(pin_oe, 3'b000);
      chk(pin_out, 3'b000);
      chk({hreadyout, hresp}, 2'b10);
      tick(1);
      bus(1'b0, OFS_CH0_IO_HIGH, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h3c, 32'h0);
      chk(q, 32'h0);
      $display("reset test done");
      stop_test;
   end
endmodule
`default_nettype wire
